/* shared/sps_cfg.svh */
// register map, field positions, reset values and counts of the serial port
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// register byte offsets
`define SPS_A_CON3 8'h00
`define SPS_A_CTRL 8'h04
`define SPS_A_OWN 8'h08
`define SPS_A_STAT 8'h0c
`define SPS_A_BUF 8'h10
`define SPS_A_IST 8'h14
`define SPS_A_IMSK 8'h18

// control register three fields
`define SPS_B_ACKPH 7
`define SPS_B_STOPIE 6
`define SPS_B_STARTIE 5
`define SPS_B_OVWEN 4
`define SPS_B_HOLDSEL 3
`define SPS_B_COLLEN 2
`define SPS_B_ADDRHOLD 1
`define SPS_B_DATAHOLD 0

// control and status fields
`define SPS_B_SPI 0
`define SPS_B_CLKREL 1
`define SPS_B_FULL 0
`define SPS_B_OV 1
`define SPS_B_RW 2
`define SPS_B_TX 3

// interrupt status and mask fields
`define SPS_I_START 0
`define SPS_I_STOP 1
`define SPS_I_BYTE 2
`define SPS_I_OV 3
`define SPS_I_COLL 4
`define SPS_IRQ_W 5

// reset values
`define SPS_CON3_RST 8'h00
`define SPS_OWN_RST 7'h10
`define SPS_IRQ_RST 5'h00

// bit counts
`define SPS_ACK_CNT 4'd8
`define SPS_END_CNT 4'd9
`define SPS_SPI_LAST 3'd7

// bus answers
`define SPS_RESP_OK 2'b00
`define SPS_RESP_ERR 2'b10

`endif

/* shared/sps_pkg.sv */
// types shared by the serial port auxiliary control modules
package sps_pkg;

	// serial pins as seen from outside
	typedef struct packed {
		logic scl;
		logic sda;
		logic sck;
		logic ssN;
		logic mosi;
	} sps_pins_t;

	// bus events found on the synchronised pins
	typedef struct packed {
		logic sclRise;
		logic sclFall;
		logic start;
		logic stop;
		logic sckRise;
	} sps_cond_t;

	// slave protocol state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_RX,
		ST_TX
	} sps_state_t;

endpackage : sps_pkg

/* design/sps_sync2.sv */
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
module sps_sync2 import sps_pkg::*; (
	input wire logic ref_clk, // system clock
	input wire logic reset, // async reset, high
	input wire sps_pins_t pinsIn, // raw pins
	output sps_pins_t pinsOut // synchronised pins
);

	sps_pins_t meta_r;

	// first stage feeds only the second
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_r <= '1;
			pinsOut <= '1;
		end else begin
			meta_r <= pinsIn;
			pinsOut <= meta_r;
		end
	end

endmodule : sps_sync2

/* design/sps_bus_cond.sv */
// edge, start and stop detection on synchronised serial pins
`timescale 1ns/1ps
module sps_bus_cond import sps_pkg::*; (
	input wire logic ref_clk, // system clock
	input wire logic reset, // async reset, high
	input wire sps_pins_t pins, // synchronised pins
	output sps_cond_t cond // one-cycle event pulses
);

	logic sclPrev_r, sdaPrev_r, sckPrev_r;

	// remember last sample of the scl, sda and sck lines
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
			sckPrev_r <= 1'b1;
		end else begin
			sclPrev_r <= pins.scl;
			sdaPrev_r <= pins.sda;
			sckPrev_r <= pins.sck;
		end
	end

	// data moving while clock stays high marks start or stop
	always_comb begin
		cond.sclRise = pins.scl && !sclPrev_r;
		cond.sclFall = !pins.scl && sclPrev_r;
		cond.start = pins.scl && sclPrev_r && sdaPrev_r && !pins.sda;
		cond.stop = pins.scl && sclPrev_r && !sdaPrev_r && pins.sda;
		cond.sckRise = pins.sck && !sckPrev_r;
	end

endmodule : sps_bus_cond

/* design/sps_aux_ctrl.sv */
// auxiliary control, status and bus watch logic of the serial port
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sps_cfg.svh"
// Notes on behaviour
// - ack flag set 8th fall, cleared 9th rise
// - ack flag only live with address/data hold
// - start interrupt only when start enable set
// - overwrite on: load and acknowledge despite full buffer
// - spi overflow still flagged under overwrite
// - data low while releasing high: collision, idle
// - address hold clears release bit, holds clock
// - spi overwrite loads buffer though unread
module sps_aux_ctrl import sps_pkg::*; (
	input wire logic ref_clk, // system clock, 100 MHz
	input wire logic reset, // async reset, high
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [7:0] awaddr, // write byte address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write byte lanes
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response code
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [7:0] araddr, // read byte address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response code
	input wire sps_pins_t pinsIn, // serial pins in
	output logic sclOutEnN, // low drives clock low
	output logic sdaOutEnN, // low drives data low
	output logic sdaHoldLong, // long data hold select
	output logic irq // level interrupt
);

	// address decode shared by read and write paths
	function automatic logic regHit(input logic [7:0] a,
		input logic [7:0] off);
		regHit = (a[7:2] == off[7:2]);
	endfunction : regHit

	sps_pins_t pins;
	sps_cond_t cond;
	sps_state_t state_r;
	logic [7:0] con3_r, ownShift_r, shiftBuf_r, txData_r, txShift_r;
	logic [7:0] spiShift_r, spiNext, rdVal;
	logic [6:0] ownAddr_r;
	logic [3:0] riseCnt_r, wStrb_r;
	logic [2:0] spiCnt_r;
	logic [4:0] irqSt_r, irqMask_r, irqEv, irqClr;
	logic [31:0] wData_r;
	logic [7:0] awAddr_r;
	logic spiMode_r, clkRel_r, bufFull_r, ov_r, rw_r, ack_phase_flag_r, sdaLow_r;
	logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
	logic i2cOn, ovwEn, addrHoldEn, dataHoldEn, collDetEn, holdOn, ackFlag;
	logic byteEnd, addrHit, take, i2cLoad, i2cOvr, spiDone, spiLoad;
	logic spiOvr, collEv, txShiftEv, wrDo, wrOk, arHs, bufRead, rdErr;

	sps_sync2 u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pinsIn(pinsIn),
		.pinsOut(pins)
	);

	sps_bus_cond u_cond (
		.ref_clk(ref_clk),
		.reset(reset),
		.pins(pins),
		.cond(cond)
	);

	// configuration views
	assign i2cOn = !spiMode_r;
	assign ovwEn = con3_r[`SPS_B_OVWEN];
	assign addrHoldEn = con3_r[`SPS_B_ADDRHOLD];
	assign dataHoldEn = con3_r[`SPS_B_DATAHOLD];
	assign collDetEn = con3_r[`SPS_B_COLLEN];
	assign holdOn = addrHoldEn || dataHoldEn;
	assign ackFlag = ack_phase_flag_r && holdOn;
	assign sdaHoldLong = con3_r[`SPS_B_HOLDSEL];

	// end of a received i2c byte and what to do with it
	assign byteEnd = i2cOn && cond.sclFall && riseCnt_r == `SPS_ACK_CNT
		&& (state_r == ST_ADDR || state_r == ST_RX);
	assign addrHit = ownShift_r[7:1] == ownAddr_r;
	assign take = byteEnd && (state_r == ST_RX || addrHit);
	assign i2cLoad = take && (ovwEn || !bufFull_r);
	assign i2cOvr = take && !ovwEn && bufFull_r;

	// spi byte completion
	assign spiNext = {spiShift_r[6:0], pins.mosi};
	assign spiDone = spiMode_r && cond.sckRise && !pins.ssN
		&& spiCnt_r == `SPS_SPI_LAST;
	assign spiLoad = spiDone && (ovwEn || !bufFull_r);
	assign spiOvr = spiDone && bufFull_r;

	// released-high bit seen low while transmitting
	assign collEv = i2cOn && state_r == ST_TX && collDetEn && cond.sclRise
		&& riseCnt_r < `SPS_ACK_CNT && txShift_r[7] && !pins.sda;
	assign txShiftEv = state_r == ST_TX && cond.sclFall
		&& riseCnt_r != 4'd0 && riseCnt_r < `SPS_ACK_CNT;

	// i2c slave state and rising edge count
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			riseCnt_r <= 4'd0;
		end else if (!i2cOn || cond.stop || collEv) begin
			state_r <= ST_IDLE;
			riseCnt_r <= 4'd0;
		end else if (cond.start) begin
			state_r <= ST_ADDR;
			riseCnt_r <= 4'd0;
		end else begin
			if (cond.sclRise && riseCnt_r != `SPS_END_CNT)
				riseCnt_r <= riseCnt_r + 4'd1;
			else if (cond.sclFall && riseCnt_r == `SPS_END_CNT)
				riseCnt_r <= 4'd0;
			case (state_r)
				ST_ADDR: begin
					if (byteEnd)
						state_r <= !addrHit ? ST_IDLE
							: (ownShift_r[0] ? ST_TX : ST_RX);
				end
				ST_TX: begin
					if (cond.sclRise && riseCnt_r == `SPS_ACK_CNT
						&& pins.sda)
						state_r <= ST_IDLE; // master did not acknowledge
				end
				default: state_r <= state_r;
			endcase
		end
	end

	// incoming i2c bits on clock rise
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			ownShift_r <= 8'h00;
		else if (cond.sclRise && riseCnt_r < `SPS_ACK_CNT)
			ownShift_r <= {ownShift_r[6:0], pins.sda};
	end

	// direction bit of the matched address
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			rw_r <= 1'b0;
		else if (byteEnd && state_r == ST_ADDR && addrHit)
			rw_r <= ownShift_r[0];
	end

	// outgoing i2c bits, loaded after each acknowledge
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			txShift_r <= 8'hff;
		else if (cond.sclFall && riseCnt_r == `SPS_END_CNT)
			txShift_r <= txData_r;
		else if (txShiftEv)
			txShift_r <= {txShift_r[6:0], 1'b1};
	end

	// data line pull-down: acknowledge or transmitted zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			sdaLow_r <= 1'b0;
		else if (!i2cOn || cond.start || cond.stop || collEv)
			sdaLow_r <= 1'b0;
		else if (byteEnd)
			sdaLow_r <= i2cLoad;
		else if (cond.sclFall && riseCnt_r == `SPS_END_CNT)
			sdaLow_r <= state_r == ST_TX && !txData_r[7];
		else if (txShiftEv)
			sdaLow_r <= !txShift_r[6];
		else if (state_r == ST_TX && cond.sclFall
			&& riseCnt_r == `SPS_ACK_CNT)
			sdaLow_r <= 1'b0;
	end
	assign sdaOutEnN = !sdaLow_r;

	// acknowledge phase flag
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			ack_phase_flag_r <= 1'b0;
		else if (!i2cOn || cond.start || cond.stop || collEv)
			ack_phase_flag_r <= 1'b0;
		else if (cond.sclFall && riseCnt_r == `SPS_ACK_CNT
			&& state_r != ST_IDLE && holdOn)
			ack_phase_flag_r <= 1'b1;
		else if (cond.sclRise && riseCnt_r == `SPS_ACK_CNT)
			ack_phase_flag_r <= 1'b0;
	end

	// clock release bit; hardware clear wins over software
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			clkRel_r <= 1'b1;
		else if (take && ((state_r == ST_ADDR && addrHoldEn)
			|| (state_r == ST_RX && dataHoldEn)))
			clkRel_r <= 1'b0;
		else if (wrOk && regHit(awAddr_r, `SPS_A_CTRL))
			clkRel_r <= wData_r[`SPS_B_CLKREL];
	end
	assign sclOutEnN = !(i2cOn && !clkRel_r);

	// spi slave shifter, bit count reset by deselect
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			spiCnt_r <= 3'd0;
			spiShift_r <= 8'h00;
		end else if (!spiMode_r || pins.ssN) begin
			spiCnt_r <= 3'd0;
		end else if (cond.sckRise) begin
			spiCnt_r <= spiCnt_r + 3'd1;
			spiShift_r <= spiNext;
		end
	end

	// receive buffer contents
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			shiftBuf_r <= 8'h00;
		else if (i2cLoad)
			shiftBuf_r <= ownShift_r;
		else if (spiLoad)
			shiftBuf_r <= spiNext;
	end

	// buffer full: a load wins over a read
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			bufFull_r <= 1'b0;
		else if (i2cLoad || spiLoad)
			bufFull_r <= 1'b1;
		else if (bufRead)
			bufFull_r <= 1'b0;
	end

	// overflow: set wins over write-one clear
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			ov_r <= 1'b0;
		else if (i2cOvr || spiOvr)
			ov_r <= 1'b1;
		else if (wrOk && regHit(awAddr_r, `SPS_A_STAT)
			&& wData_r[`SPS_B_OV])
			ov_r <= 1'b0;
	end

	// sticky interrupt sources
	always_comb begin
		irqEv = `SPS_IRQ_RST;
		irqEv[`SPS_I_START] = i2cOn && cond.start
			&& con3_r[`SPS_B_STARTIE];
		irqEv[`SPS_I_STOP] = i2cOn && cond.stop
			&& con3_r[`SPS_B_STOPIE];
		irqEv[`SPS_I_BYTE] = i2cLoad || spiLoad;
		irqEv[`SPS_I_OV] = i2cOvr || spiOvr;
		irqEv[`SPS_I_COLL] = collEv;
		irqClr = (wrOk && regHit(awAddr_r, `SPS_A_IST))
			? wData_r[`SPS_IRQ_W-1:0] : `SPS_IRQ_RST;
	end

	// interrupt status: new events win over clearing
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			irqSt_r <= `SPS_IRQ_RST;
		else
			irqSt_r <= (irqSt_r & ~irqClr) | irqEv;
	end
	assign irq = |(irqSt_r & irqMask_r);

	// axi write channel capture
	assign awready = !awHeld_r && !bvalid_r;
	assign wready = !wHeld_r && !bvalid_r;
	assign wrDo = awHeld_r && wHeld_r && !bvalid_r;
	assign wrOk = wrDo && wStrb_r[0];
	assign bvalid = bvalid_r;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp <= `SPS_RESP_OK;
		end else begin
			if (awvalid && awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			if (wrDo) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp <= (awAddr_r > `SPS_A_IMSK + 8'h03)
					? `SPS_RESP_ERR : `SPS_RESP_OK;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// software-written registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			con3_r <= `SPS_CON3_RST;
			spiMode_r <= 1'b0;
			ownAddr_r <= `SPS_OWN_RST;
			txData_r <= 8'hff;
			irqMask_r <= `SPS_IRQ_RST;
		end else if (wrOk) begin
			if (regHit(awAddr_r, `SPS_A_CON3))
				con3_r <= {1'b0, wData_r[6:0]};
			if (regHit(awAddr_r, `SPS_A_CTRL))
				spiMode_r <= wData_r[`SPS_B_SPI];
			if (regHit(awAddr_r, `SPS_A_OWN))
				ownAddr_r <= wData_r[6:0];
			if (regHit(awAddr_r, `SPS_A_BUF))
				txData_r <= wData_r[7:0];
			if (regHit(awAddr_r, `SPS_A_IMSK))
				irqMask_r <= wData_r[`SPS_IRQ_W-1:0];
		end
	end

	// read decode
	always_comb begin
		rdVal = 8'h00;
		rdErr = 1'b0;
		if (regHit(araddr, `SPS_A_CON3))
			rdVal = {ackFlag, con3_r[6:0]};
		else if (regHit(araddr, `SPS_A_CTRL))
			rdVal = {6'h00, clkRel_r, spiMode_r};
		else if (regHit(araddr, `SPS_A_OWN))
			rdVal = {1'b0, ownAddr_r};
		else if (regHit(araddr, `SPS_A_STAT))
			rdVal = {4'h0, state_r == ST_TX, rw_r, ov_r, bufFull_r};
		else if (regHit(araddr, `SPS_A_BUF))
			rdVal = shiftBuf_r;
		else if (regHit(araddr, `SPS_A_IST))
			rdVal = {3'h0, irqSt_r};
		else if (regHit(araddr, `SPS_A_IMSK))
			rdVal = {3'h0, irqMask_r};
		else
			rdErr = 1'b1;
	end

	// axi read channel, one cycle answer
	assign arready = !rvalid_r;
	assign arHs = arvalid && arready;
	assign bufRead = arHs && regHit(araddr, `SPS_A_BUF);
	assign rvalid = rvalid_r;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rvalid_r <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `SPS_RESP_OK;
		end else if (arHs) begin
			rvalid_r <= 1'b1;
			rdata <= {24'h00_0000, rdVal};
			rresp <= rdErr ? `SPS_RESP_ERR : `SPS_RESP_OK;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_ack_set: assert property (
		(i2cOn && cond.sclFall && riseCnt_r == `SPS_ACK_CNT && holdOn
		&& state_r != ST_IDLE && !cond.start && !cond.stop && !collEv)
		|=> ack_phase_flag_r ##1 (ack_phase_flag_r || $past(cond.sclRise)))
		else $error("ack flag not set on eighth fall");
	a_ack_clear: assert property (
		(cond.sclRise && riseCnt_r == `SPS_ACK_CNT) |=> !ack_phase_flag_r)
		else $error("ack flag not cleared on ninth rise");
	a_ack_gate: assert property (
		(arHs && regHit(araddr, `SPS_A_CON3) && !holdOn)
		|=> rvalid && !rdata[`SPS_B_ACKPH])
		else $error("ack flag visible without hold enable");
	a_start_irq: assert property (
		(i2cOn && cond.start && con3_r[`SPS_B_STARTIE])
		|=> irqSt_r[`SPS_I_START])
		else $error("start interrupt missing");
	a_start_quiet: assert property (
		(cond.start && !con3_r[`SPS_B_STARTIE] && !irqSt_r[`SPS_I_START])
		|=> !irqSt_r[`SPS_I_START])
		else $error("start interrupt while disabled");
	a_stop_irq: assert property (
		(i2cOn && cond.stop && con3_r[`SPS_B_STOPIE])
		|=> irqSt_r[`SPS_I_STOP] && state_r == ST_IDLE)
		else $error("stop interrupt missing");
	a_ovr_ack: assert property (
		(take && ovwEn) |=> !sdaOutEnN && bufFull_r
		&& shiftBuf_r == $past(ownShift_r))
		else $error("overwrite byte not loaded or acknowledged");
	a_spi_ovf: assert property (
		(spiDone && bufFull_r) |=> ov_r && irqSt_r[`SPS_I_OV])
		else $error("spi overflow not flagged");
	a_bus_coll: assert property (
		collEv |=> state_r == ST_IDLE && sdaOutEnN
		&& irqSt_r[`SPS_I_COLL])
		else $error("collision not handled");
	a_addr_hold: assert property (
		(take && state_r == ST_ADDR && addrHoldEn)
		|=> !clkRel_r && !sclOutEnN ##1 (!sclOutEnN || $past(wrOk)))
		else $error("address hold did not stretch clock");
	a_spi_load: assert property (
		(spiDone && ovwEn) |=> bufFull_r && shiftBuf_r == $past(spiNext))
		else $error("spi overwrite did not load buffer");

	c_start: cover property (i2cOn && cond.start ##[1:300] byteEnd);
	c_hold: cover property (take && addrHoldEn ##1 !sclOutEnN);
	c_coll: cover property (collEv);
	c_spi_ov: cover property (spiDone && bufFull_r && ovwEn);

endmodule : sps_aux_ctrl

/* verif/sps_far_master.sv */
// behavioural external i2c and spi master driving the serial pins
`timescale 1ns/1ps
module sps_far_master import sps_pkg::*; (
	output sps_pins_t pins, // pins seen by the device
	input wire logic sclOutEnN, // device pulls clock low
	input wire logic sdaOutEnN // device pulls data low
);
	localparam time Q = 40ns; // quarter of the 160 ns link period
	logic mScl = 1'b1;
	logic mSda = 1'b1;
	logic sck = 1'b0;
	logic ssN = 1'b1;
	logic mosi = 1'b0;
	// open drain lines with pull-ups, spi clock stands still between bytes
	assign pins = '{scl: mScl & sclOutEnN, sda: mSda & sdaOutEnN,
		sck: sck, ssN: ssN, mosi: mosi};
	task i2cStart;
		#7;
		mSda = 1'b0;
		#Q;
		mScl = 1'b0;
		#Q;
	endtask : i2cStart
	task i2cStop;
		mSda = 1'b0;
		#Q;
		mScl = 1'b1;
		#Q;
		mSda = 1'b1;
		#Q;
	endtask : i2cStop
	// one clock, waits while the device stretches it
	task pulse(output logic s);
		#Q;
		mScl = 1'b1;
		wait (pins.scl);
		#Q;
		s = pins.sda;
		#Q;
		mScl = 1'b0;
		#Q;
	endtask : pulse
	task wrByte(input logic [7:0] d, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			mSda = d[i];
			pulse(s);
		end
		mSda = 1'b1;
		pulse(nak);
	endtask : wrByte
	// clash pulls data low on the first bit on purpose
	task rdByte(input logic clash, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			mSda = !(clash && i == 7);
			pulse(d[i]);
		end
		mSda = 1'b1;
		pulse(s);
	endtask : rdByte
	task spiByte(input logic [7:0] d);
		#7;
		ssN = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = d[i];
			#(2 * Q);
			sck = 1'b1;
			#(2 * Q);
			sck = 1'b0;
		end
	endtask : spiByte
	// deselect, released data line no longer shows the last bit
	task spiEnd;
		#Q;
		ssN = 1'b1;
		mosi = ~mosi;
	endtask : spiEnd
endmodule : sps_far_master

/* verif/testbench.sv */
// self-checking bench for the serial port auxiliary control
`timescale 1ns/1ps
`include "sps_cfg.svh"
module testbench import sps_pkg::*; ;
	localparam logic [1:0] respOk = `SPS_RESP_OK;
	localparam logic [1:0] respErr = `SPS_RESP_ERR;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic sclOutEnN, sdaOutEnN, sdaHoldLong;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	sps_pins_t pins;
	logic [33:0] rdQ[$];
	logic [1:0] wrQ[$];
	logic [33:0] rExp;
	logic [1:0] bExp;
	int miscompares = 0;
	int checks = 0;
	logic nak;
	logic [7:0] d1, d2, d3, rb;
	sps_aux_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.pinsIn(pins), .sclOutEnN(sclOutEnN), .sdaOutEnN(sdaOutEnN),
		.sdaHoldLong(sdaHoldLong), .irq(irq));
	sps_far_master i_far (.pins(pins), .sclOutEnN(sclOutEnN),
		.sdaOutEnN(sdaOutEnN));
	// 100 MHz clock and six cycle reset
	always #5 ref_clk = ~ref_clk;
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
	end
	task final_report;
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t pin level %b", $time, got);
		end
	endtask : chk
	// write: address and data offered together, each released when taken
	task axWr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aOk, wOk;
		aOk = 1'b0;
		wOk = 1'b0;
		wrQ.push_back(er);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aOk && wOk)) begin
			@(posedge ref_clk);
			aOk = aOk | awready;
			wOk = wOk | wready;
			if (aOk)
				awvalid <= 1'b0;
			if (wOk)
				wvalid <= 1'b0;
		end
		do @(posedge ref_clk); while (!bvalid);
		bready <= 1'b0;
	endtask : axWr
	task axRd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		rdQ.push_back({er, 24'h0, d});
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (!rvalid);
		rready <= 1'b0;
	endtask : axRd
	// watcher: compares each bus answer with the oldest note
	always @(posedge ref_clk) begin
		if (rvalid && rready) begin
			rExp = rdQ.pop_front();
			checks++;
			if ({rresp, rdata} !== rExp) begin
				miscompares++;
				$display("ERROR %0t read got %h want %h", $time, rdata, rExp);
			end
		end
		if (bvalid && bready) begin
			bExp = wrQ.pop_front();
			checks++;
			if (bresp !== bExp) begin
				miscompares++;
				$display("ERROR %0t write resp %b", $time, bresp);
			end
		end
	end
	// watchdog
	initial begin
		#300us;
		miscompares++;
		final_report();
	end
	// main sequence
	initial begin
		void'($urandom(32'h3a90));
		wait (!reset);
		axRd(`SPS_A_CON3, 8'h00, respOk);
		axRd(`SPS_A_CTRL, 8'h02, respOk);
		axRd(`SPS_A_OWN, 8'h10, respOk);
		axRd(8'h1c, 8'h00, respErr);
		axWr(8'h1c, 8'hff, respErr);
		axWr(`SPS_A_CON3, 8'h08, respOk);
		chk(sdaHoldLong, 1'b1);
		axWr(`SPS_A_IMSK, 8'h1f, respOk);
		// start and stop with their enables clear, then set
		axWr(`SPS_A_CON3, 8'h00, respOk);
		i_far.i2cStart();
		i_far.i2cStop();
		axRd(`SPS_A_IST, 8'h00, respOk);
		axWr(`SPS_A_CON3, 8'h60, respOk);
		i_far.i2cStart();
		i_far.i2cStop();
		axRd(`SPS_A_IST, 8'h03, respOk);
		chk(irq, 1'b1);
		axWr(`SPS_A_IMSK, 8'h00, respOk);
		@(posedge ref_clk);
		chk(irq, 1'b0);
		axWr(`SPS_A_IST, 8'h03, respOk);
		axWr(`SPS_A_IMSK, 8'h1f, respOk);
		// address hold stretches the clock until released
		axWr(`SPS_A_CON3, 8'h02, respOk);
		fork
			begin
				i_far.i2cStart();
				i_far.wrByte(8'h20, nak);
			end
		join_none
		wait (sclOutEnN == 1'b0);
		axRd(`SPS_A_CON3, 8'h82, respOk);
		axRd(`SPS_A_CTRL, 8'h00, respOk);
		chk(sclOutEnN, 1'b0);
		axRd(`SPS_A_BUF, 8'h20, respOk);
		axWr(`SPS_A_CTRL, 8'h02, respOk);
		wait fork;
		chk(nak, 1'b0);
		axRd(`SPS_A_CON3, 8'h02, respOk);
		d1 = 8'($urandom);
		i_far.wrByte(d1, nak);
		chk(nak, 1'b0);
		axRd(`SPS_A_BUF, d1, respOk);
		i_far.i2cStop();
		axRd(`SPS_A_IST, 8'h04, respOk);
		axWr(`SPS_A_IST, 8'h1f, respOk);
		// full buffer without and with overwrite
		axWr(`SPS_A_CON3, 8'h00, respOk);
		d2 = 8'($urandom);
		d3 = 8'($urandom);
		i_far.i2cStart();
		i_far.wrByte(8'h20, nak);
		i_far.wrByte(d2, nak);
		chk(nak, 1'b1);
		axRd(`SPS_A_STAT, 8'h03, respOk);
		axRd(`SPS_A_BUF, 8'h20, respOk);
		axWr(`SPS_A_STAT, 8'h02, respOk);
		axWr(`SPS_A_CON3, 8'h10, respOk);
		i_far.wrByte(d2, nak);
		i_far.wrByte(d3, nak);
		chk(nak, 1'b0);
		axRd(`SPS_A_BUF, d3, respOk);
		i_far.i2cStop();
		axWr(`SPS_A_STAT, 8'h02, respOk);
		axWr(`SPS_A_IST, 8'h1f, respOk);
		// spi slave with overwrite, two unread bytes
		axWr(`SPS_A_CTRL, 8'h03, respOk);
		i_far.spiByte(d1);
		i_far.spiByte(d2);
		i_far.spiEnd();
		axRd(`SPS_A_STAT, 8'h03, respOk);
		axRd(`SPS_A_BUF, d2, respOk);
		axWr(`SPS_A_STAT, 8'h02, respOk);
		axWr(`SPS_A_IST, 8'h1f, respOk);
		axWr(`SPS_A_CTRL, 8'h02, respOk);
		// data pulled low while the device sends a one
		axWr(`SPS_A_CON3, 8'h04, respOk);
		// top bit released, lower zeros would pull data low if not idle
		axWr(`SPS_A_BUF, 8'h80, respOk);
		i_far.i2cStart();
		i_far.wrByte(8'h21, nak);
		chk(nak, 1'b0);
		axRd(`SPS_A_STAT, 8'h0d, respOk);
		i_far.rdByte(1'b1, rb);
		chk(sdaOutEnN, 1'b1);
		chk(rb == 8'h7f, 1'b1);
		i_far.i2cStop();
		axRd(`SPS_A_IST, 8'h14, respOk);
		chk(irq, 1'b1);
		axWr(`SPS_A_IST, 8'h1f, respOk);
		@(posedge ref_clk);
		chk(irq, 1'b0);
		final_report();
	end
endmodule : testbench
